// >>> verilog/bpm_consts.svh
// Purpose: offsets, field positions, reset values for the bridge protection block
// Assumes: 32-bit APB, byte addresses
// Notes: definitions only
`ifndef BPM_CONSTS_SVH
`define BPM_CONSTS_SVH

`define BPM_ADDR_W 12
`define BPM_CTRL_OFS 12'h000
`define BPM_STATUS_OFS 12'h004
`define BPM_PINS_OFS 12'h008
`define BPM_CTRL_MODE_LSB 0
`define BPM_CTRL_MODE_MSB 1
`define BPM_CTRL_RESET 2'h0
`define BPM_SYNC_STAGES 2
`define BPM_SYNC_CLR_IDLE 2'h3

`endif

// >>> verilog/bpm_pkg.sv
// Purpose: types used by the bridge protection block, not by its bench
// Assumes: four half-bridges A..D, index 0..3
// Notes: constants live in bpm_consts.svh
package bpm_pkg;

   // operating modes, value held in the control register
   typedef enum logic [1:0] {
      BPM_MODE_FULL_CBC = 2'h0,
      BPM_MODE_FULL_LATCH = 2'h1,
      BPM_MODE_PARALLEL = 2'h2,
      BPM_MODE_ONE_INPUT = 2'h3
   } bpm_mode_t;

   // status word as read from the status register
   typedef struct packed {
      logic [1:0] mode;
      logic [3:0] cbc_block;
      logic [3:0] oc_latched;
      logic overtemp_warning;
      logic por_ok;
      logic undervoltage;
      logic thermal_shutdown;
   } bpm_status_t;

   // gate drive of the four half-bridges
   typedef struct packed {
      logic [3:0] high_gate;
      logic [3:0] low_gate;
      logic [3:0] hiz;
      logic [3:0] weak_pulldown;
   } bpm_drive_t;

endpackage

// >>> verilog/bpm_bridge_protect.sv
// Purpose: input routing and protection of a four half-bridge driver
// Assumes: analog comparators arrive as asynchronous digital pins
// Notes: pins pass two flip-flops; registers reached over APB
//
// Overview of operation
// - warning low while hot above warning level
// - shutdown heat: all bridges Hi-Z, fault low
// - thermal shutdown latched until pair clears
// - both pair clears must rise to clear
// - power-on clear resets overcurrent until supplies good
// - undervoltage: all Hi-Z, fault low at once
// - undervoltage not latched, recovers by itself
// - low pair clear forces its pair Hi-Z
// - low pair clear enables weak pulldown
// - pair clear rise clears its pair overcurrent
// - four modes selectable
// - modes 1,2: each input drives own bridge
// - mode 2: no cycle limiting, latch only
// - mode 3: A drives AB, B drives CD
// - parallel pairs switch in lockstep
// - parallel: either clear low, all Hi-Z
// - mode 4: A and C drive complementary pairs
// - cycle limit holds driver off until toggle
// - low-side trip keeps high side off too
// - severe overcurrent latches bridge Hi-Z in modes 1,3,4
// - latched mode: trip shuts down until cleared
// - protection independent per half-bridge, except mode 3
`timescale 1ns/1ps
`include "bpm_consts.svh"

module bpm_bridge_protect #(
   parameter int NUM_SUPPLIES = 5
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RESET_N_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [`BPM_ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // controller pins
   input wire logic [3:0] PHASE_IN_I,
   input wire logic PAIR_ONE_CLEAR_N_I,
   input wire logic PAIR_TWO_CLEAR_N_I,
   // analog monitors
   input wire logic TEMP_WARN_I,
   input wire logic TEMP_SHUTDOWN_I,
   input wire logic POWER_GOOD_I,
   input wire logic [NUM_SUPPLIES-1:0] SUPPLY_UNDERVOLT_I,
   input wire logic [3:0] OC_HIGH_I,
   input wire logic [3:0] OC_LOW_I,
   input wire logic [3:0] OC_SEVERE_I,
   // power stage
   output logic [3:0] HIGH_GATE_O,
   output logic [3:0] LOW_GATE_O,
   output logic [3:0] HIZ_O,
   output logic [3:0] WEAK_PULLDOWN_O,
   // status pins
   output logic OVERTEMP_WARNING_N_O,
   output logic FAULT_N_O
);

   localparam int SW = 21 + NUM_SUPPLIES;

   if (NUM_SUPPLIES < 1 || NUM_SUPPLIES > 8) begin : g_bad_supplies
      $error("NUM_SUPPLIES must be 1 to 8");
   end

   // ****************************************
   // helper functions
   // ****************************************
   // phase input feeding each half-bridge in a mode
   function automatic logic [3:0] route(input bpm_pkg::bpm_mode_t m, input logic [3:0] p);
      logic [3:0] c;
      c = p;
      case (m)
         bpm_pkg::BPM_MODE_PARALLEL: begin
            c = {p[1], p[1], p[0], p[0]};
         end
         bpm_pkg::BPM_MODE_ONE_INPUT: begin
            c = {~p[2], p[2], ~p[0], p[0]};
         end
         default: begin
            c = p;
         end
      endcase
      return c;
   endfunction

   // spread a per-bridge flag across its pair
   function automatic logic [3:0] pair_or(input logic [3:0] v);
      return {{2{v[3] | v[2]}}, {2{v[1] | v[0]}}};
   endfunction

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [SW-1:0] pins_raw;
   logic [SW-1:0] sync1_r;
   logic [SW-1:0] sync2_r;

   assign pins_raw = {SUPPLY_UNDERVOLT_I, OC_SEVERE_I, OC_LOW_I, OC_HIGH_I, POWER_GOOD_I,
                      TEMP_SHUTDOWN_I, TEMP_WARN_I, PAIR_TWO_CLEAR_N_I,
                      PAIR_ONE_CLEAR_N_I, PHASE_IN_I};

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         // clears start released, else the first sample after reset looks like a rise
         sync1_r <= {{(SW - 6){1'b0}}, `BPM_SYNC_CLR_IDLE, 4'h0};
         sync2_r <= {{(SW - 6){1'b0}}, `BPM_SYNC_CLR_IDLE, 4'h0};
      end else begin
         sync1_r <= pins_raw;
         sync2_r <= sync1_r;
      end
   end

   logic [3:0] phase_s;
   logic clr1_n_s;
   logic clr2_n_s;
   logic warn_s;
   logic hot_s;
   logic pgood_s;
   logic [3:0] oc_hi_s;
   logic [3:0] oc_lo_s;
   logic [3:0] oc_sev_s;
   logic [NUM_SUPPLIES-1:0] uv_s;

   assign phase_s = sync2_r[3:0];
   assign clr1_n_s = sync2_r[4];
   assign clr2_n_s = sync2_r[5];
   assign warn_s = sync2_r[6];
   assign hot_s = sync2_r[7];
   assign pgood_s = sync2_r[8];
   assign oc_hi_s = sync2_r[12:9];
   assign oc_lo_s = sync2_r[16:13];
   assign oc_sev_s = sync2_r[20:17];
   assign uv_s = sync2_r[SW-1:21];

   // ****************************************
   // edge detection
   // ****************************************
   logic clr1_prev_r;
   logic clr2_prev_r;
   logic [3:0] cmd_prev_r;
   logic rise1;
   logic rise2;
   logic [3:0] cmd;
   logic [3:0] cmd_edge;
   bpm_pkg::bpm_mode_t mode_r;

   assign rise1 = clr1_n_s & ~clr1_prev_r;
   assign rise2 = clr2_n_s & ~clr2_prev_r;
   assign cmd = route(mode_r, phase_s);
   assign cmd_edge = cmd ^ cmd_prev_r;

   // previous clear levels start high so a released pin after reset is no edge
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         clr1_prev_r <= 1'b1;
         clr2_prev_r <= 1'b1;
         cmd_prev_r <= 4'h0;
      end else begin
         clr1_prev_r <= clr1_n_s;
         clr2_prev_r <= clr2_n_s;
         cmd_prev_r <= cmd;
      end
   end

   // ****************************************
   // supply monitoring
   // ****************************************
   logic por_ok_r;
   logic uv_now;

   assign uv_now = |uv_s;

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         por_ok_r <= 1'b0;
      end else begin
         por_ok_r <= pgood_s;
      end
   end

   // ****************************************
   // thermal shutdown latch
   // ****************************************
   logic thermal_r;
   logic rose1_r;
   logic rose2_r;
   logic both_rose;

   assign both_rose = (rose1_r | rise1) & (rose2_r | rise2);

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         thermal_r <= 1'b0;
      end else if (hot_s) begin
         thermal_r <= 1'b1;
      end else if (thermal_r && both_rose) begin
         thermal_r <= 1'b0;
      end
   end

   // remember which pair clear has risen since the shutdown
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I || !thermal_r || both_rose) begin
         rose1_r <= 1'b0;
         rose2_r <= 1'b0;
      end else begin
         rose1_r <= rose1_r | rise1;
         rose2_r <= rose2_r | rise2;
      end
   end

   // ****************************************
   // overcurrent handling
   // ****************************************
   logic cbc_mode;
   logic [3:0] oc_any;
   logic [3:0] pair_rise;
   logic [3:0] cbc_r;
   logic [3:0] oc_latch_r;
   logic [3:0] oc_latch_set;
   logic [3:0] cbc_set;

   assign cbc_mode = (mode_r != bpm_pkg::BPM_MODE_FULL_LATCH);
   assign oc_any = oc_hi_s | oc_lo_s;
   assign pair_rise = {rise2, rise2, rise1, rise1};
   assign cbc_set = cbc_mode ? oc_any : 4'h0;
   assign oc_latch_set = cbc_mode ? oc_sev_s : oc_any;

   // a trip turns both switches of the bridge off until the next input edge
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I || !por_ok_r) begin
         cbc_r <= 4'h0;
      end else begin
         cbc_r <= cbc_set | (cbc_r & ~cmd_edge);
      end
   end

   // set wins over a simultaneous clearing edge
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I || !por_ok_r) begin
         oc_latch_r <= 4'h0;
      end else begin
         oc_latch_r <= oc_latch_set | (oc_latch_r & ~pair_rise);
      end
   end

   // ****************************************
   // gate drive
   // ****************************************
   logic [3:0] pair_clear_low;
   logic [3:0] block;
   logic [3:0] stop;
   logic global_stop;
   bpm_pkg::bpm_drive_t drive_nxt;
   bpm_pkg::bpm_drive_t drive_r;

   assign global_stop = thermal_r | uv_now | ~por_ok_r;

   always_comb begin
      pair_clear_low = {~clr2_n_s, ~clr2_n_s, ~clr1_n_s, ~clr1_n_s};
      block = cbc_r | oc_latch_r;
      if (mode_r == bpm_pkg::BPM_MODE_PARALLEL) begin
         block = pair_or(block);
         if (!clr1_n_s || !clr2_n_s) begin
            pair_clear_low = 4'hF;
         end
      end
      stop = block | pair_clear_low | {4{global_stop}};
      drive_nxt.high_gate = cmd & ~stop;
      drive_nxt.low_gate = ~cmd & ~stop;
      drive_nxt.hiz = stop;
      drive_nxt.weak_pulldown = {~clr2_n_s, ~clr2_n_s, ~clr1_n_s, ~clr1_n_s};
   end

   // power stage starts off and Hi-Z
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         drive_r <= '{high_gate: 4'h0, low_gate: 4'h0, hiz: 4'hF, weak_pulldown: 4'h0};
      end else begin
         drive_r <= drive_nxt;
      end
   end

   assign HIGH_GATE_O = drive_r.high_gate;
   assign LOW_GATE_O = drive_r.low_gate;
   assign HIZ_O = drive_r.hiz;
   assign WEAK_PULLDOWN_O = drive_r.weak_pulldown;

   // ****************************************
   // status pins
   // ****************************************
   logic warn_n_r;
   logic fault_n_r;

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         warn_n_r <= 1'b1;
         fault_n_r <= 1'b0;
      end else begin
         warn_n_r <= ~warn_s;
         fault_n_r <= ~(|oc_latch_r | thermal_r | uv_now | ~por_ok_r);
      end
   end

   assign OVERTEMP_WARNING_N_O = warn_n_r;
   assign FAULT_N_O = fault_n_r;

   // ****************************************
   // apb register file
   // ****************************************
   // one wait state keeps read data and ready straight from flip-flops
   logic access;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_nxt;
   logic hit;
   bpm_pkg::bpm_status_t status;

   assign access = PSEL_I & PENABLE_I;

   always_comb begin
      status.mode = mode_r;
      status.cbc_block = cbc_r;
      status.oc_latched = oc_latch_r;
      status.overtemp_warning = warn_s;
      status.por_ok = por_ok_r;
      status.undervoltage = uv_now;
      status.thermal_shutdown = thermal_r;
      hit = 1'b1;
      rd_nxt = 32'h0000_0000;
      case (PADDR_I)
         `BPM_CTRL_OFS: begin
            rd_nxt[`BPM_CTRL_MODE_MSB:`BPM_CTRL_MODE_LSB] = mode_r;
         end
         `BPM_STATUS_OFS: begin
            rd_nxt[$bits(status)-1:0] = status;
         end
         `BPM_PINS_OFS: begin
            rd_nxt[SW-1:0] = sync2_r;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= access & ~pready_r;
         pslverr_r <= access & ~pready_r & ~hit;
         prdata_r <= (access && !pready_r && !PWRITE_I) ? rd_nxt : 32'h0000_0000;
      end
   end

   // mode write lands at the completing edge only
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         mode_r <= bpm_pkg::bpm_mode_t'(`BPM_CTRL_RESET);
      end else if (access && pready_r && PWRITE_I && PADDR_I == `BPM_CTRL_OFS) begin
         mode_r <= bpm_pkg::bpm_mode_t'(PWDATA_I[`BPM_CTRL_MODE_MSB:`BPM_CTRL_MODE_LSB]);
      end
   end

   assign PREADY_O = pready_r;
   assign PSLVERR_O = pslverr_r;
   assign PRDATA_O = prdata_r;

endmodule

// >>> testbench/bpm_bridge_protect_assertions.sv
// Purpose: port timing checks for the bridge protection block
// Assumes: pins pass two sync flops and an output flop
// Notes: four-sample windows leave one cycle of slack, none for heat and power good
`timescale 1ns/1ps
module bpm_checker #(
   parameter int NUM_SUPPLIES = 5
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RESET_N_I,
   // inputs watched
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PAIR_ONE_CLEAR_N_I,
   input wire logic TEMP_WARN_I,
   input wire logic TEMP_SHUTDOWN_I,
   input wire logic POWER_GOOD_I,
   input wire logic [NUM_SUPPLIES-1:0] SUPPLY_UNDERVOLT_I,
   // outputs watched
   input wire logic PREADY_O,
   input wire logic [3:0] HIGH_GATE_O,
   input wire logic [3:0] LOW_GATE_O,
   input wire logic [3:0] HIZ_O,
   input wire logic [3:0] WEAK_PULLDOWN_O,
   input wire logic OVERTEMP_WARNING_N_O,
   input wire logic FAULT_N_O
);
   // ********
   // checks
   // ********
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   a_warn_set: assert property (TEMP_WARN_I [*4] |=> !OVERTEMP_WARNING_N_O)
      else $error("warning not low");
   a_warn_free: assert property (!TEMP_WARN_I [*4] |=> OVERTEMP_WARNING_N_O)
      else $error("warning not released");
   a_heat_off: assert property (TEMP_SHUTDOWN_I [*4] |=> HIZ_O == 4'hF && !FAULT_N_O)
      else $error("no thermal shutdown");
   a_uv_off: assert property ((|SUPPLY_UNDERVOLT_I) [*4] |=> HIZ_O == 4'hF && !FAULT_N_O)
      else $error("no undervoltage shutdown");
   a_por_fault: assert property (!POWER_GOOD_I [*4] |=> !FAULT_N_O)
      else $error("fault high without power good");
   a_clear_hold: assert property (!PAIR_ONE_CLEAR_N_I [*4] |=>
      (&HIZ_O[1:0]) && (&WEAK_PULLDOWN_O[1:0]))
      else $error("pair one not held off");
   a_gates_off: assert property (((HIZ_O | LOW_GATE_O) & HIGH_GATE_O) == 4'h0)
      else $error("high gate on with hiz or low gate");
   a_hiz_low: assert property ((HIZ_O & LOW_GATE_O) == 4'h0)
      else $error("low gate on in hiz");
   a_ready_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O ##1 !PREADY_O)
      else $error("ready timing wrong");
endmodule
bind bpm_bridge_protect bpm_checker #(.NUM_SUPPLIES(NUM_SUPPLIES)) u_bpm_checker (.*);

// >>> testbench/bpm_ctrl_model.sv
// Purpose: controller model driving phase and pair clear pins
// Assumes: bench requests arrive as one-cycle pulses
// Notes: clears are only ever pulsed, never left low
`timescale 1ns/1ps
module bpm_ctrl_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // bench requests
   input wire logic load_i,
   input wire logic [3:0] set_i,
   input wire logic [3:0] flip_i,
   input wire logic [1:0] pulse_i,
   // pins toward the block
   output logic [3:0] phase_o,
   output logic [1:0] clr_n_o
);
   // ********
   // pins
   // ********
   logic [3:0] lo_r [2];
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) phase_o <= 4'h0;
      else if (load_i) phase_o <= set_i;
      else phase_o <= phase_o ^ flip_i;
   end
   always_ff @(posedge clk_i) begin
      for (int k = 0; k < 2; k++) begin
         if (!rst_n_i) lo_r[k] <= 4'h0;
         else if (pulse_i[k]) lo_r[k] <= 4'h8;
         else if (lo_r[k] != 4'h0) lo_r[k] <= lo_r[k] - 4'h1;
      end
   end
   assign clr_n_o = {lo_r[1] == 4'h0, lo_r[0] == 4'h0};
endmodule

// >>> testbench/tb.sv
// Purpose: self-checking bench for the bridge protection block
// Assumes: 100 MHz clock, fixed xorshift seed
// Notes: waits of six cycles cover the three-edge pin latency
`timescale 1ns/1ps
`include "bpm_consts.svh"
module tb;
   logic clk, rst_n, psel, pen, pwr, rdy, serr, load, tw, ts, pg, warn_n, flt_n;
   logic [11:0] paddr;
   logic [31:0] pwd, prd, rd, v;
   logic [3:0] set, flip, ohi, olo, osv, hg, lg, hz, wp, ph;
   logic [1:0] pulse, clr;
   logic [4:0] uv;
   int err_total = 0, tests_run = 0, seed = 67, m;
   bpm_bridge_protect u_bpm_bridge_protect (
      .SYS_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd),
      .PREADY_O(rdy), .PSLVERR_O(serr), .PHASE_IN_I(ph),
      .PAIR_ONE_CLEAR_N_I(clr[0]), .PAIR_TWO_CLEAR_N_I(clr[1]),
      .TEMP_WARN_I(tw), .TEMP_SHUTDOWN_I(ts), .POWER_GOOD_I(pg),
      .SUPPLY_UNDERVOLT_I(uv), .OC_HIGH_I(ohi), .OC_LOW_I(olo),
      .OC_SEVERE_I(osv), .HIGH_GATE_O(hg), .LOW_GATE_O(lg), .HIZ_O(hz),
      .WEAK_PULLDOWN_O(wp), .OVERTEMP_WARNING_N_O(warn_n), .FAULT_N_O(flt_n)
   );
   bpm_ctrl_model u_bpm_ctrl_model (
      .clk_i(clk), .rst_n_i(rst_n), .load_i(load), .set_i(set), .flip_i(flip),
      .pulse_i(pulse), .phase_o(ph), .clr_n_o(clr)
   );
   // ********
   // helpers
   // ********
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [11:0] exp_drv(input int md, input logic [3:0] p);
      logic [3:0] c;
      case (md)
         2: c = {p[1], p[1], p[0], p[0]};
         3: c = {~p[2], p[2], ~p[0], p[0]};
         default: c = p;
      endcase
      return {c, ~c, 4'h0};
   endfunction
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (n > 20) begin
            err_total++;
            finish_test();
         end
      end while (rdy !== 1'b1);
      rd = prd;
      v = {31'h0, serr};
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic tog(input logic [3:0] f, input logic [1:0] p, input int n);
      @(posedge clk);
      flip <= f;
      pulse <= p;
      @(posedge clk);
      flip <= 4'h0;
      pulse <= 2'h0;
      cyc(n);
   endtask
   task automatic setph(input logic [3:0] p);
      @(posedge clk);
      load <= 1'b1;
      set <= p;
      @(posedge clk);
      load <= 1'b0;
      cyc(6);
   endtask
   task automatic oc(input logic [3:0] h, input logic [3:0] l);
      @(posedge clk);
      ohi <= h;
      olo <= l;
      cyc(2);
      ohi <= 4'h0;
      olo <= 4'h0;
      cyc(6);
   endtask
   // ********
   // sequence
   // ********
   initial begin
      cyc(20000);
      err_total++;
      finish_test();
   end
   initial begin
      {rst_n, psel, pen, pwr, load, tw, ts, pg, uv, ohi, olo, osv} = 25'h2_0000;
      {paddr, pwd, set, flip, pulse} = 54'h0;
      cyc(10);
      chk({hg, lg, hz, wp, warn_n}, {8'h0, 4'hF, 4'h0, 1'b1});
      rst_n <= 1'b1;
      cyc(6);
      for (m = 0; m < 4; m++) begin
         apb(1'b1, `BPM_CTRL_OFS, m);
         apb(1'b0, `BPM_CTRL_OFS, 32'h0);
         chk(rd[1:0], m);
         repeat (4) begin
            v = xs();
            setph(v[3:0]);
            chk({hg, lg, hz}, exp_drv(m, v[3:0]));
         end
      end
      $display("test 1 routing finished");
      apb(1'b1, `BPM_CTRL_OFS, 32'h0);
      setph(4'h0);
      oc(4'h0, 4'h1);
      chk({hz, hg[0], lg[0], flt_n}, {4'h1, 3'b001});
      tog(4'h1, 2'h0, 6);
      chk({hg, lg, hz}, exp_drv(0, 4'h1));
      $display("test 2 cycle limit finished");
      apb(1'b1, `BPM_CTRL_OFS, 32'h1);
      setph(4'h0);
      oc(4'h4, 4'h0);
      chk({hz, flt_n}, {4'h4, 1'b0});
      tog(4'h4, 2'h0, 6);
      chk(hz, 4'h4);
      tog(4'h0, 2'h2, 14);
      chk({hg, lg, hz, flt_n}, {exp_drv(1, 4'h4), 1'b1});
      $display("test 3 latched trip finished");
      @(posedge clk);
      {tw, ts} <= 2'h3;
      cyc(6);
      chk({warn_n, flt_n, hz}, {2'b00, 4'hF});
      {tw, ts} <= 2'h0;
      cyc(6);
      chk({warn_n, flt_n, hz}, {2'b10, 4'hF});
      tog(4'h0, 2'h1, 14);
      chk(flt_n, 1'b0);
      tog(4'h0, 2'h2, 14);
      chk({flt_n, hz}, {1'b1, 4'h0});
      $display("test 4 thermal finished");
      uv <= 5'h1 << (xs() % 5);
      cyc(6);
      chk({flt_n, hz}, {1'b0, 4'hF});
      uv <= 5'h0;
      cyc(6);
      chk({flt_n, hz}, {1'b1, 4'h0});
      pg <= 1'b0;
      cyc(6);
      chk({flt_n, hz}, {1'b0, 4'hF});
      pg <= 1'b1;
      cyc(6);
      chk(flt_n, 1'b1);
      $display("test 5 supplies finished");
      tog(4'h0, 2'h1, 6);
      chk({hz, wp}, {4'h3, 4'h3});
      cyc(8);
      apb(1'b1, `BPM_CTRL_OFS, 32'h2);
      tog(4'h0, 2'h2, 6);
      chk({hz, wp}, {4'hF, 4'hC});
      cyc(8);
      $display("test 6 pair clears finished");
      apb(1'b1, 12'h00C, 32'h3);
      chk(v, 32'h1);
      apb(1'b0, `BPM_CTRL_OFS, 32'h0);
      chk(rd[1:0], 2'h2);
      apb(1'b0, 12'h00C, 32'h0);
      chk({v[0], rd}, {1'b1, 32'h0});
      $display("test 7 bus refusal finished");
      oc(4'h0, 4'h1);
      chk(hz, 4'h3);
      tog(4'h1, 2'h0, 6);
      chk({hg, lg, hz}, exp_drv(2, 4'h5));
      apb(1'b1, `BPM_CTRL_OFS, 32'h0);
      osv <= 4'h8;
      cyc(2);
      osv <= 4'h0;
      cyc(6);
      chk({hz, flt_n}, {4'h8, 1'b0});
      apb(1'b0, `BPM_STATUS_OFS, 32'h0);
      chk(rd, 32'h84);
      tog(4'h0, 2'h2, 14);
      chk({hz, flt_n}, {4'h0, 1'b1});
      $display("test 8 pairs and severe trip finished");
      finish_test();
   end
endmodule
